// [rtl/eer_regs.vh]
// Constants for the two-wire serial memory read and protect block.
`ifndef EER_REGS_VH
`define EER_REGS_VH

// Clock period of clock_i in nanoseconds.
`define EER_CLK_PERIOD_NS 5

// Time the array stays busy after a stored write, in nanoseconds.
`define EER_PROG_TIME_NS 5000

// Busy time as whole clock cycles, rounded up.
`define EER_PROG_CYCLES \
    ((`EER_PROG_TIME_NS + `EER_CLK_PERIOD_NS - 1) / `EER_CLK_PERIOD_NS)

// Width of the busy counter.
`define EER_PROG_CNT_W 11

// Memory geometry: four blocks of 256 bytes.
`define EER_ADDR_W 10
`define EER_DEPTH 1024

// Control byte fields.
`define EER_DEV_CODE 4'ha
`define EER_CODE_MSB 7
`define EER_CODE_LSB 4
`define EER_BLK_MSB 2
`define EER_BLK_LSB 1
`define EER_RW_BIT 0

// Receive phases.
`define EER_PH_CTRL 2'h0
`define EER_PH_ADDR 2'h1
`define EER_PH_DATA 2'h2

`endif

// [rtl/eer_mem.v]
// Byte array with one write port and one registered read port.
`timescale 1ns/1ps
`include "eer_regs.vh"

module eer_mem
(
    // Clock and reset.
    input wire clock_i,
    input wire rst_n_i,
    // Write port.
    input wire wr_en_i,
    input wire [`EER_ADDR_W-1:0] wr_addr_i,
    input wire [7:0] wr_data_i,
    // Read port.
    input wire rd_en_i,
    input wire [`EER_ADDR_W-1:0] rd_addr_i,
    output reg [7:0] rd_data_o
);

    reg [7:0] mem [0:`EER_DEPTH-1];

    always @(posedge clock_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_data_o <= 8'h00;
        end
        else if (rd_en_i)
        begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule

// [rtl/eer_top.v]
// Two-wire serial memory slave with read path and write protection.
// How it works
// R1: Address byte after write control loads pointer.
// R2: Repeated start ends write phase, keeps stored bytes and pointer.
// R3: Master resends control byte with read bit.
// R4: Acknowledge read control, send byte MSB first.
// R5: No master acknowledge releases data line.
// R6: Master acknowledge sends next addressed byte.
// R7: Pointer increments after each byte.
// R8: Pointer spans the whole array.
// R9: Low supply blocks all writes.
// R10: Data changes only while clock low.
// R11: Transitions during clock high are start/stop.
// R12: Data line only pulled low or released.
// R13: Write protect high refuses all programming.
// R14: Write protect leaves reads unchanged.
// R15: Spare select pins are ignored.
// R16: Control byte is code, block bits, direction.
// R17: Falling data is start, rising is stop.
// R18: No acknowledge during programming cycle.
// R19: Acknowledge held low over ninth clock high.
// R20: Pointer wraps from last address to zero.
`timescale 1ns/1ps
`include "eer_regs.vh"

module eer_top
(
    // Clock and reset.
    input wire clock_i,
    input wire rst_n_i,
    // Serial bus.
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    // Protection and straps.
    input wire wp_i,
    input wire low_supply_i,
    input wire [2:0] spare_select_pins_i,
    // Status.
    output reg busy_o
);

    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_RX = 5'h02;
    localparam [4:0] S_ACK = 5'h04;
    localparam [4:0] S_TX = 5'h08;
    localparam [4:0] S_MACK = 5'h10;

    // The busy count is worked out at full width, then cut to the counter.
    localparam integer PROG_CYCLES_FULL = `EER_PROG_CYCLES;
    localparam [`EER_PROG_CNT_W-1:0] PROG_CYCLES =
        PROG_CYCLES_FULL[`EER_PROG_CNT_W-1:0];

    // Three-stage input samplers.
    reg [2:0] scl_q;
    reg [2:0] sda_q;
    reg [2:0] wp_q;
    reg [2:0] low_q;
    reg scl_s;
    reg sda_s;
    reg wp_s;
    reg low_s;

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            wp_q <= 3'h0;
            low_q <= 3'h0;
        end
        else
        begin
            scl_q <= {scl_q[1:0], scl_i};
            sda_q <= {sda_q[1:0], sda_i};
            wp_q <= {wp_q[1:0], wp_i};
            low_q <= {low_q[1:0], low_supply_i};
        end
    end

    wire scl_ok = (scl_q[1] == scl_q[2]);
    wire sda_ok = (sda_q[1] == sda_q[2]);
    wire scl_rise = scl_ok & scl_q[2] & ~scl_s;
    wire scl_fall = scl_ok & ~scl_q[2] & scl_s;
    wire sda_rise = sda_ok & sda_q[2] & ~sda_s;
    wire sda_fall = sda_ok & ~sda_q[2] & sda_s;
    // Data edges while the clock is steadily high frame the transfer.
    wire start_cond = sda_fall & scl_s & ~scl_fall; // R11 R17
    wire stop_cond = sda_rise & scl_s & ~scl_fall; // R11 R17

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            scl_s <= 1'b1;
            sda_s <= 1'b1;
            wp_s <= 1'b0;
            low_s <= 1'b0;
        end
        else
        begin
            if (scl_ok)
            begin
                scl_s <= scl_q[2];
            end
            if (sda_ok)
            begin
                sda_s <= sda_q[2];
            end
            if (wp_q[1] == wp_q[2])
            begin
                wp_s <= wp_q[2];
            end
            if (low_q[1] == low_q[2])
            begin
                low_s <= low_q[2];
            end
        end
    end

    // The spare select pins feed only an unused OR that drives nothing.
    wire unused_pins = |spare_select_pins_i; // R15

    // Writes are allowed only with protection off and supply good.
    wire write_ok = ~wp_s & ~low_s; // R9 R13

    // Protocol state.
    reg [4:0] state;
    reg [1:0] phase;
    reg [3:0] bit_cnt;
    reg [7:0] shreg;
    reg [7:0] txsh;
    reg rd_mode;
    reg [1:0] blk;
    reg [`EER_ADDR_W-1:0] ptr;
    reg wrote;
    reg master_ack;
    reg [`EER_PROG_CNT_W-1:0] prog_cnt;
    reg mem_we;
    reg [`EER_ADDR_W-1:0] mem_wa;
    reg [7:0] mem_wd;
    reg flush;
    reg fifo_pop;

    // Prefetch path and two-entry buffer.
    reg [`EER_ADDR_W-1:0] fetch_addr;
    reg rd_pend;
    reg [7:0] buf0;
    reg [7:0] buf1;
    reg [1:0] buf_cnt;
    wire [7:0] rd_data;
    wire buf_in_ready = (buf_cnt != 2'h2);
    wire buf_out_valid = (buf_cnt != 2'h0);
    wire buf_push = rd_pend & buf_in_ready & ~flush;
    wire buf_take = fifo_pop & buf_out_valid;
    // Fetch stalls while the buffer is full or a read is in flight.
    wire rd_issue = ~flush & ~rd_pend & buf_in_ready & rd_mode;

    eer_mem u_mem
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(mem_we),
        .wr_addr_i(mem_wa),
        .wr_data_i(mem_wd),
        .rd_en_i(rd_issue),
        .rd_addr_i(fetch_addr),
        .rd_data_o(rd_data)
    );

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_pend <= 1'b0;
            fetch_addr <= {`EER_ADDR_W{1'b0}};
            buf0 <= 8'h00;
            buf1 <= 8'h00;
            buf_cnt <= 2'h0;
        end
        else if (flush)
        begin
            rd_pend <= 1'b0;
            fetch_addr <= {blk, ptr[7:0]}; // R16
            buf_cnt <= 2'h0;
        end
        else
        begin
            rd_pend <= rd_issue | (rd_pend & ~buf_push);
            if (rd_issue)
            begin
                fetch_addr <= fetch_addr + 1'b1; // R8 R20
            end
            case ({buf_push, buf_take})
                2'b10:
                begin
                    if (buf_cnt == 2'h0)
                    begin
                        buf0 <= rd_data;
                    end
                    else
                    begin
                        buf1 <= rd_data;
                    end
                    buf_cnt <= buf_cnt + 2'h1;
                end
                2'b01:
                begin
                    buf0 <= buf1;
                    buf_cnt <= buf_cnt - 2'h1;
                end
                2'b11:
                begin
                    if (buf_cnt == 2'h1)
                    begin
                        buf0 <= rd_data;
                    end
                    else
                    begin
                        buf0 <= buf1;
                        buf1 <= rd_data;
                    end
                end
                default:
                begin
                    buf_cnt <= buf_cnt;
                end
            endcase
        end
    end

    // Serial protocol engine.
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= S_IDLE;
            phase <= `EER_PH_CTRL;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            txsh <= 8'h00;
            rd_mode <= 1'b0;
            blk <= 2'h0;
            ptr <= {`EER_ADDR_W{1'b0}};
            wrote <= 1'b0;
            master_ack <= 1'b0;
            prog_cnt <= {`EER_PROG_CNT_W{1'b0}};
            mem_we <= 1'b0;
            mem_wa <= {`EER_ADDR_W{1'b0}};
            mem_wd <= 8'h00;
            flush <= 1'b0;
            fifo_pop <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            busy_o <= 1'b0;
        end
        else
        begin
            mem_we <= 1'b0;
            flush <= 1'b0;
            fifo_pop <= 1'b0;
            sda_o <= 1'b0; // R12
            busy_o <= (prog_cnt != {`EER_PROG_CNT_W{1'b0}});
            if (prog_cnt != {`EER_PROG_CNT_W{1'b0}})
            begin
                prog_cnt <= prog_cnt - 1'b1;
            end
            if (start_cond)
            begin
                // A repeated start ends the write phase; bytes already stored stay, and ptr is kept.
                state <= S_RX; // R2
                phase <= `EER_PH_CTRL;
                bit_cnt <= 4'h0;
                rd_mode <= 1'b0;
                sda_oe_o <= 1'b0;
            end
            else if (stop_cond)
            begin
                state <= S_IDLE;
                rd_mode <= 1'b0;
                sda_oe_o <= 1'b0;
                if (wrote)
                begin
                    prog_cnt <= PROG_CYCLES;
                end
                wrote <= 1'b0;
            end
            else
            begin
                case (state)
                    S_IDLE:
                    begin
                        sda_oe_o <= 1'b0;
                    end
                    S_RX:
                    begin
                        if (scl_rise)
                        begin
                            shreg <= {shreg[6:0], sda_s}; // R10
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (scl_fall && bit_cnt == 4'h8)
                        begin
                            bit_cnt <= 4'h0;
                            if (phase == `EER_PH_CTRL)
                            begin
                                if (shreg[`EER_CODE_MSB:`EER_CODE_LSB] ==
                                    `EER_DEV_CODE && !busy_o) // R16 R18
                                begin
                                    state <= S_ACK;
                                    sda_oe_o <= 1'b1; // R19
                                    rd_mode <= shreg[`EER_RW_BIT];
                                    blk <= shreg[`EER_BLK_MSB:`EER_BLK_LSB];
                                    if (shreg[`EER_RW_BIT])
                                    begin
                                        flush <= 1'b1; // R3 R4
                                        ptr <= {shreg[`EER_BLK_MSB:
                                            `EER_BLK_LSB], ptr[7:0]};
                                    end
                                end
                                else
                                begin
                                    state <= S_IDLE;
                                end
                            end
                            else if (phase == `EER_PH_ADDR)
                            begin
                                ptr <= {blk, shreg}; // R1
                                state <= S_ACK;
                                sda_oe_o <= 1'b1; // R19
                            end
                            else
                            begin
                                if (write_ok) // R9 R13
                                begin
                                    mem_we <= 1'b1;
                                    mem_wa <= ptr;
                                    mem_wd <= shreg;
                                    wrote <= 1'b1;
                                end
                                ptr <= ptr + 1'b1; // R7 R20
                                state <= S_ACK;
                                sda_oe_o <= 1'b1; // R19
                            end
                        end
                    end
                    S_ACK:
                    begin
                        if (scl_fall)
                        begin
                            if (rd_mode)
                            begin
                                // First read byte, bit 7 goes out now.
                                txsh <= buf0; // R4 R14
                                fifo_pop <= 1'b1;
                                sda_oe_o <= ~buf0[7]; // R10 R12
                                state <= S_TX;
                            end
                            else
                            begin
                                sda_oe_o <= 1'b0;
                                state <= S_RX;
                                if (phase == `EER_PH_CTRL)
                                begin
                                    phase <= `EER_PH_ADDR;
                                end
                                else
                                begin
                                    phase <= `EER_PH_DATA;
                                end
                            end
                        end
                    end
                    S_TX:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt == 4'h7)
                            begin
                                bit_cnt <= 4'h0;
                                sda_oe_o <= 1'b0;
                                ptr <= ptr + 1'b1; // R7 R8 R20
                                state <= S_MACK;
                            end
                            else
                            begin
                                bit_cnt <= bit_cnt + 4'h1;
                                txsh <= {txsh[6:0], 1'b0};
                                sda_oe_o <= ~txsh[6]; // R10 R12
                            end
                        end
                    end
                    S_MACK:
                    begin
                        if (scl_rise)
                        begin
                            master_ack <= ~sda_s;
                        end
                        else if (scl_fall)
                        begin
                            if (master_ack)
                            begin
                                txsh <= buf0; // R6
                                fifo_pop <= 1'b1;
                                sda_oe_o <= ~buf0[7];
                                state <= S_TX;
                            end
                            else
                            begin
                                sda_oe_o <= 1'b0; // R5
                                state <= S_IDLE;
                            end
                        end
                    end
                    default:
                    begin
                        state <= S_IDLE;
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// [bench/eer_monitor.sv]
// Port checker for the two-wire serial memory slave.
`timescale 1ns/1ps
module eer_monitor
(
    // Clock and reset.
    input wire clock_i,
    input wire rst_n_i,
    // Serial bus.
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_o,
    // Protection, straps and status.
    input wire wp_i,
    input wire low_supply_i,
    input wire [2:0] spare_select_pins_i,
    input wire busy_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_start;
        scl_i && $fell(sda_i);
    endsequence
    sequence s_stop;
        scl_i && $rose(sda_i);
    endsequence
    sequence s_released;
        (!sda_oe_o) [*8];
    endsequence

    property p_pull_only;
        sda_o == 1'b0;
    endproperty
    property p_oe_moves_low;
        $changed(sda_oe_o) |-> !scl_i && !$past(scl_i);
    endproperty
    property p_ack_holds;
        $rose(scl_i) |-> $stable(sda_oe_o) [*8];
    endproperty
    property p_start_frees;
        s_start |=> s_released;
    endproperty
    property p_stop_frees;
        s_stop |=> s_released;
    endproperty
    property p_busy_quiet;
        busy_o |-> !sda_oe_o;
    endproperty
    property p_wp_blocks;
        $rose(busy_o) |-> !wp_i && !$past(wp_i, 4);
    endproperty
    property p_low_blocks;
        $rose(busy_o) |-> !low_supply_i;
    endproperty

    a_pull_only: assert property (p_pull_only)
        else $error("data line driven high");
    a_oe_moves_low: assert property (p_oe_moves_low)
        else $error("data drive changed with clock high");
    a_ack_holds: assert property (p_ack_holds)
        else $error("data drive moved during clock high");
    a_start_frees: assert property (p_start_frees)
        else $error("line driven after start");
    a_stop_frees: assert property (p_stop_frees)
        else $error("line driven after stop");
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("acknowledge while busy");
    a_wp_blocks: assert property (p_wp_blocks)
        else $error("programming with protect high");
    a_low_blocks: assert property (p_low_blocks)
        else $error("programming with low supply");
endmodule

bind eer_top eer_monitor mon_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i), .busy_o(busy_o),
    .low_supply_i(low_supply_i), .spare_select_pins_i(spare_select_pins_i)
);

// [bench/eer_master.sv]
// Bus master model that drives the serial clock and the data line.
`timescale 1ns/1ps
module eer_master
(
    // Clock.
    input wire clock_i,
    // Serial bus.
    input wire sda_i,
    output reg scl_o,
    output reg sda_low_o
);
    // Extra low-phase cycles; stretches the clock to stall the slave.
    integer slow = 0;
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task wait_clk(input integer n);
        repeat (n) @(posedge clock_i);
    endtask
    task bit_io(input b, output r);
        begin
            wait_clk(2);
            sda_low_o <= ~b;
            wait_clk(6 + slow);
            scl_o <= 1'b1;
            wait_clk(8);
            r = sda_i;
            scl_o <= 1'b0;
        end
    endtask
    task start;
        begin
            wait_clk(2);
            sda_low_o <= 1'b0;
            wait_clk(6);
            scl_o <= 1'b1;
            wait_clk(8);
            sda_low_o <= 1'b1;
            wait_clk(8);
            scl_o <= 1'b0;
        end
    endtask
    task stop;
        begin
            wait_clk(2);
            sda_low_o <= 1'b1;
            wait_clk(6);
            scl_o <= 1'b1;
            wait_clk(8);
            sda_low_o <= 1'b0;
            wait_clk(16);
        end
    endtask
    task wr_byte(input [7:0] d, output ack);
        integer k;
        reg r;
        begin
            for (k = 7; k >= 0; k = k - 1)
                bit_io(d[k], r);
            bit_io(1'b1, r);
            ack = ~r;
        end
    endtask
    task rd_byte(input ack_m, output [7:0] d);
        integer k;
        reg r;
        begin
            for (k = 7; k >= 0; k = k - 1)
            begin
                bit_io(1'b1, r);
                d[k] = r;
            end
            bit_io(~ack_m, r);
        end
    endtask
endmodule

// [bench/test_serial_eeprom_read_and_protect.sv]
// Self-checking bench for the serial memory read and protect block.
`timescale 1ns/1ps
`include "eer_regs.vh"
module test_serial_eeprom_read_and_protect;
    reg clock_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg wp = 1'b0;
    reg low = 1'b0;
    reg [2:0] spare = 3'h0;
    wire scl;
    wire d_sda;
    wire d_oe;
    wire busy;
    wire m_low;
    // Open-drain line with pull-up: low when any party pulls it.
    wire sda = ~(m_low | (d_oe & ~d_sda));
    reg [7:0] exp_mem [0:1023];
    reg [7:0] got;
    reg ack;
    integer n_mismatch = 0;
    integer tests_run = 0;
    integer i;
    integer k;
    initial
    begin
        forever #2.5 clock_i = ~clock_i;
    end
    eer_top dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
        .sda_o(d_sda), .sda_oe_o(d_oe), .wp_i(wp), .low_supply_i(low),
        .spare_select_pins_i(spare), .busy_o(busy)
    );
    eer_master m_u (
        .clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low)
    );
    function [7:0] ctrl(input [1:0] blk, input rd);
        ctrl = {`EER_DEV_CODE, 1'b0, blk, rd};
    endfunction
    task check(input [7:0] g, input [7:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e)
            begin
                n_mismatch = n_mismatch + 1;
                $display("BAD t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task wr_seq(input [9:0] a, input integer n);
        reg [7:0] d;
        begin
            spare <= 3'($urandom);
            m_u.start();
            m_u.wr_byte(ctrl(a[9:8], 1'b0), ack);
            check({7'h0, ack}, 8'h01);
            m_u.wr_byte(a[7:0], ack);
            check({7'h0, ack}, 8'h01);
            for (i = 0; i < n; i = i + 1)
            begin
                d = 8'($urandom);
                m_u.wr_byte(d, ack);
                check({7'h0, ack}, 8'h01);
                if (!wp && !low)
                    exp_mem[10'(a + i)] = d;
            end
            m_u.stop();
        end
    endtask
    task rd_seq(input [9:0] a, input integer n);
        begin
            spare <= 3'($urandom);
            m_u.start();
            m_u.wr_byte(ctrl(a[9:8], 1'b0), ack);
            m_u.wr_byte(a[7:0], ack);
            check({7'h0, ack}, 8'h01);
            m_u.start();
            m_u.wr_byte(ctrl(a[9:8], 1'b1), ack);
            check({7'h0, ack}, 8'h01);
            for (i = 0; i < n; i = i + 1)
            begin
                m_u.rd_byte(i < n - 1, got);
                check(got, exp_mem[10'(a + i)]);
            end
            m_u.wait_clk(8);
            check({7'h0, sda}, 8'h01);
            m_u.stop();
        end
    endtask
    task wait_idle;
        begin
            k = 0;
            while (busy !== 1'b0 && k < 3000)
            begin
                @(posedge clock_i);
                k = k + 1;
            end
            check({7'h0, busy}, 8'h00);
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial
    begin
        repeat (60000) @(posedge clock_i);
        n_mismatch = n_mismatch + 1;
        results();
    end
    initial
    begin
        i = $urandom(81);
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        m_u.wait_clk(8);
        wr_seq(10'h3fe, 4);
        m_u.wait_clk(20);
        check({7'h0, busy}, 8'h01);
        m_u.start();
        m_u.wr_byte(ctrl(2'h3, 1'b1), ack);
        check({7'h0, ack}, 8'h00);
        m_u.stop();
        wait_idle();
        rd_seq(10'h3fe, 4);
        m_u.start();
        m_u.wr_byte(8'h5d, ack);
        check({7'h0, ack}, 8'h00);
        m_u.stop();
        wp <= 1'b1;
        wr_seq(10'h3fe, 2);
        m_u.wait_clk(20);
        check({7'h0, busy}, 8'h00);
        rd_seq(10'h3fe, 3);
        wp <= 1'b0;
        low <= 1'b1;
        wr_seq(10'h000, 2);
        m_u.wait_clk(20);
        check({7'h0, busy}, 8'h00);
        low <= 1'b0;
        m_u.slow = 40;
        wr_seq(10'h120, 3);
        wait_idle();
        rd_seq(10'h120, 3);
        m_u.slow = 0;
        rd_seq(10'h3ff, 3);
        results();
    end
endmodule
